// ### t16i_pkg.sv
// package for the timer16 interrupt, capture and shared prescaler block
// assumes a single system clock and a cpu-side byte-wide register port
package t16i_pkg;

  // ------------------------------------------------------------
  // register addresses (data space)
  // ------------------------------------------------------------
  localparam logic [7:0] GTC_ADDR  = 8'h43;
  localparam logic [7:0] MASK_ADDR = 8'h6F;
  localparam logic [7:0] FLAG_ADDR = 8'h36;
  localparam logic [7:0] CAPL_ADDR = 8'h86;
  localparam logic [7:0] CAPH_ADDR = 8'h87;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int CAP_BIT  = 5;
  localparam int MB_BIT   = 2;
  localparam int MA_BIT   = 1;
  localparam int OVF_BIT  = 0;
  localparam int HOLD_BIT = 7;
  localparam int PRA_BIT  = 1;
  localparam int PRS_BIT  = 0;
  localparam logic [7:0] IRQ_USED_MASK = 8'h27;
  localparam logic [7:0] GTC_USED_MASK = 8'h83;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [7:0] GTC_RESET  = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] FLAG_RESET = 8'h00;

  // ------------------------------------------------------------
  // clock select codes and prescaler taps
  // ------------------------------------------------------------
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_D64  = 3'h3;
  localparam logic [2:0] CS_D256 = 3'h4;
  localparam logic [2:0] CS_D1K  = 3'h5;
  localparam logic [2:0] CS_EXTF = 3'h6;
  localparam logic [2:0] CS_EXTR = 3'h7;
  localparam int PRESCALE_BITS = 10;
  localparam int TAP8_BIT   = 2;
  localparam int TAP64_BIT  = 5;
  localparam int TAP256_BIT = 7;
  localparam int TAP1K_BIT  = 9;

  // ------------------------------------------------------------
  // waveform modes where the capture register is top, plus normal and clear-on-A
  // ------------------------------------------------------------
  localparam logic [3:0] WGM_PFC_CAP  = 4'h8;
  localparam logic [3:0] WGM_PC_CAP   = 4'hA;
  localparam logic [3:0] WGM_CLR_CAP  = 4'hC;
  localparam logic [3:0] WGM_FAST_CAP = 4'hE;
  localparam logic [3:0] WGM_NORMAL   = 4'h0;
  localparam logic [3:0] WGM_CLR_A    = 4'h4;

  typedef enum logic [1:0] {EXT_IDLE, EXT_SEEN} t16i_ext_t;

endpackage : t16i_pkg

// ### t16i_ext_sync.sv
// pin synchroniser and edge detector for the external count pin
// assumes pin is asynchronous; output is a one-cycle clock enable
`timescale 1ns/1ps

module t16i_ext_sync
(
  input  wire logic       clk_in,
  input  wire logic       rstn_in,
  input  wire logic       pin_in,
  input  wire logic [2:0] sel_in,
  output logic            tick_out
);

  logic latch_q;
  logic sync_q;
  logic prev_q;
  wire  rise_w = sync_q & ~prev_q;
  wire  fall_w = ~sync_q & prev_q;

  // stage chain; half-phase latch modelled as first flop, read only by sync_q
  // rising edge sampling
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      latch_q <= 1'b0;
      sync_q  <= 1'b0;
      prev_q  <= 1'b0;
    end
    else
    begin
      latch_q <= pin_in;
      sync_q  <= latch_q;
      prev_q  <= sync_q;
    end
  end

  // one pulse per chosen edge, undivided
  // edge select
  assign tick_out = ((sel_in == t16i_pkg::CS_EXTR) & rise_w) |
                    ((sel_in == t16i_pkg::CS_EXTF) & fall_w);

  ext_pulse_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    tick_out |=> !tick_out) else $error("ext tick longer than one cycle");

endmodule : t16i_ext_sync

// ### t16i_core.sv
// timer16 capture register, interrupt mask/flags and shared prescaler
// assumes cpu byte bus: addr, wdata, wr and rd strobes, reads combinational
`timescale 1ns/1ps

// Functional notes
// - capture event copies counter to capture register
// - low byte read latches high in temp
// - irq needs enable, global flag, set flag
// - unused mask and flag bits read zero
// - capture flag on event or at top
// - capture flag clears on vector or write-one
// - match flag set timer tick after equality
// - forced compare never sets match flag
// - match flags clear on vector or write-one
// - overflow flag set on overflow in normal/clear modes
// - overflow flag clears on vector or write-one
// - one prescaler, separate clock selects
// - select one direct, selects two to five taps 8..1024
// - prescaler free running, first count 1..N+1
// - prescaler reset restarts both timers' periods
// - pin sampled through rising-edge synchroniser stages
// - one tick per chosen edge
// - counter updates 2.5..3.5 clocks after edge; here 2..3, since the half-phase latch is modelled as a full flop
// - external clock bypasses prescaler
// - control holds mode and two reset bits
// - sync reset bit self clears unless mode
// - mode holds reset bits; clearing releases both
module t16i_core
#(
  parameter int CNT_W = 16
)
(
  input  wire logic             CLK_SYS_IN,
  input  wire logic             RSTN_IN,
  input  wire logic [7:0]       ADDR_IN,
  input  wire logic [7:0]       WDATA_IN,
  input  wire logic             WR_IN,
  input  wire logic             RD_IN,
  output logic      [7:0]       RDATA_OUT,
  input  wire logic             GLOBAL_IE_IN,
  input  wire logic [3:0]       VECTOR_ACK_IN,
  input  wire logic [CNT_W-1:0] COUNT_VALUE_IN,
  input  wire logic [CNT_W-1:0] COMPARE_REG_A_IN,
  input  wire logic [CNT_W-1:0] COMPARE_REG_B_IN,
  input  wire logic [3:0]       WAVEFORM_MODE_SEL_IN,
  input  wire logic             COUNT_AT_TOP_IN,
  input  wire logic             COUNT_OVERFLOW_IN,
  input  wire logic             MODE_OVF_EVENT_IN,
  input  wire logic             CAPTURE_EVENT_IN,
  input  wire logic             FORCE_MATCH_A_IN,
  input  wire logic             FORCE_MATCH_B_IN,
  input  wire logic             EXTERNAL_COUNT_PIN_IN,
  input  wire logic [2:0]       CLK_SEL16_IN,
  input  wire logic [2:0]       CLK_SEL8_IN,
  output logic                  TICK16_OUT,
  output logic                  TICK8_OUT,
  output logic                  ASYNC_PRESCALER_RESET_OUT,
  output logic [CNT_W-1:0]      CAPTURE_REGISTER_OUT,
  output logic [7:0]            FLAGS_OUT,
  output logic                  IRQ_CAPTURE_OUT,
  output logic                  IRQ_MATCH_A_OUT,
  output logic                  IRQ_MATCH_B_OUT,
  output logic                  IRQ_OVERFLOW_OUT
);

  // ------------------------------------------------------------
  // register state
  // ------------------------------------------------------------
  logic [7:0]                 gtc_q;
  logic [7:0]                 mask_q;
  logic [7:0]                 flag_q;
  logic [7:0]                 flag_d;
  logic [CNT_W-1:0]           cap_q;
  logic [7:0]                 temp_q;
  logic [t16i_pkg::PRESCALE_BITS-1:0] pre_q;
  logic                       match_a_q;
  logic                       match_b_q;
  logic                       tick16_q;

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  wire wr_gtc  = WR_IN & (ADDR_IN == t16i_pkg::GTC_ADDR);
  wire wr_mask = WR_IN & (ADDR_IN == t16i_pkg::MASK_ADDR);
  wire wr_flag = WR_IN & (ADDR_IN == t16i_pkg::FLAG_ADDR);
  wire rd_capl = RD_IN & (ADDR_IN == t16i_pkg::CAPL_ADDR);

  // tap select is shared decode for both timers
  function automatic logic tap_sel
  (
    input logic [2:0]                          sel,
    input logic [t16i_pkg::PRESCALE_BITS-1:0]  pre,
    input logic                                ext
  );
    logic r;
    r = 1'b0;
    case (sel)
      t16i_pkg::CS_DIV1: r = 1'b1;
      t16i_pkg::CS_DIV8: r = &pre[t16i_pkg::TAP8_BIT:0];
      t16i_pkg::CS_D64:  r = &pre[t16i_pkg::TAP64_BIT:0];
      t16i_pkg::CS_D256: r = &pre[t16i_pkg::TAP256_BIT:0];
      t16i_pkg::CS_D1K:  r = &pre[t16i_pkg::TAP1K_BIT:0];
      t16i_pkg::CS_EXTF: r = ext;
      t16i_pkg::CS_EXTR: r = ext;
      default:           r = 1'b0;
    endcase
    return r;
  endfunction : tap_sel

  // ------------------------------------------------------------
  // control register and prescaler
  // ------------------------------------------------------------
  wire sync_hold_mode        = gtc_q[t16i_pkg::HOLD_BIT];
  wire sync_prescaler_reset  = gtc_q[t16i_pkg::PRS_BIT];
  wire async_prescaler_reset = gtc_q[t16i_pkg::PRA_BIT];
  assign ASYNC_PRESCALER_RESET_OUT = async_prescaler_reset;

  // reset bits persist only while the hold mode is set
  // control register
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (!RSTN_IN)
      gtc_q <= t16i_pkg::GTC_RESET;
    else if (wr_gtc)
      gtc_q <= WDATA_IN & t16i_pkg::GTC_USED_MASK;
    else if (!sync_hold_mode)
      gtc_q <= gtc_q & ~8'h03;
  end

  // free running; one reset restarts both timers' periods
  // free running
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (!RSTN_IN || sync_prescaler_reset)
      pre_q <= '0;
    else
      pre_q <= pre_q + 1'b1;
  end

  // ------------------------------------------------------------
  // timer clock enables
  // ------------------------------------------------------------
  logic ext16_w;
  logic ext8_w;

  t16i_ext_sync u_ext16
  (
    .clk_in   (CLK_SYS_IN),
    .rstn_in  (RSTN_IN),
    .pin_in   (EXTERNAL_COUNT_PIN_IN),
    .sel_in   (CLK_SEL16_IN),
    .tick_out (ext16_w)
  );

  t16i_ext_sync u_ext8
  (
    .clk_in   (CLK_SYS_IN),
    .rstn_in  (RSTN_IN),
    .pin_in   (EXTERNAL_COUNT_PIN_IN),
    .sel_in   (CLK_SEL8_IN),
    .tick_out (ext8_w)
  );

  // halted timers stay still while the prescaler reset is held
  // independent selects
  wire tick16_w = ~sync_prescaler_reset & tap_sel(CLK_SEL16_IN, pre_q, ext16_w);
  wire tick8_w  = ~sync_prescaler_reset & tap_sel(CLK_SEL8_IN, pre_q, ext8_w);
  assign TICK16_OUT = tick16_w;
  assign TICK8_OUT  = tick8_w;

  // ------------------------------------------------------------
  // capture register with shared temp high byte
  // ------------------------------------------------------------
  wire cap_is_top = (WAVEFORM_MODE_SEL_IN == t16i_pkg::WGM_PFC_CAP) |
                    (WAVEFORM_MODE_SEL_IN == t16i_pkg::WGM_PC_CAP)  |
                    (WAVEFORM_MODE_SEL_IN == t16i_pkg::WGM_CLR_CAP) |
                    (WAVEFORM_MODE_SEL_IN == t16i_pkg::WGM_FAST_CAP);
  // pin is disconnected when the capture register serves as top
  wire cap_evt    = CAPTURE_EVENT_IN & ~cap_is_top;

  always_ff @(posedge CLK_SYS_IN)
  begin
    if (!RSTN_IN)
      cap_q <= '0;
    else if (cap_evt)
      cap_q <= COUNT_VALUE_IN;
  end

  always_ff @(posedge CLK_SYS_IN)
  begin
    if (!RSTN_IN)
      temp_q <= 8'h00;
    else if (rd_capl)
      temp_q <= cap_q[15:8];
  end
  assign CAPTURE_REGISTER_OUT = cap_q;

  // ------------------------------------------------------------
  // flag set and clear
  // ------------------------------------------------------------
  // equality registered so the flag lands on the following timer tick
  // one tick late
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (!RSTN_IN)
    begin
      match_a_q <= 1'b0;
      match_b_q <= 1'b0;
      tick16_q  <= 1'b0;
    end
    else if (tick16_w)
    begin
      match_a_q <= (COUNT_VALUE_IN == COMPARE_REG_A_IN);
      match_b_q <= (COUNT_VALUE_IN == COMPARE_REG_B_IN);
      tick16_q  <= 1'b1;
    end
  end

  // force strobes are deliberately not wired into any set term
  // no flag from force
  wire force_seen = FORCE_MATCH_A_IN | FORCE_MATCH_B_IN;

  wire normal_like = (WAVEFORM_MODE_SEL_IN == t16i_pkg::WGM_NORMAL) |
                     (WAVEFORM_MODE_SEL_IN == t16i_pkg::WGM_CLR_A) |
                     (WAVEFORM_MODE_SEL_IN == t16i_pkg::WGM_CLR_CAP);
  logic [7:0] set_w;
  logic [7:0] clr_w;

  assign set_w[t16i_pkg::CAP_BIT] = cap_evt | (cap_is_top & COUNT_AT_TOP_IN);
  assign set_w[t16i_pkg::MB_BIT]  = tick16_w & tick16_q & match_b_q;
  assign set_w[t16i_pkg::MA_BIT]  = tick16_w & tick16_q & match_a_q;
  assign set_w[t16i_pkg::OVF_BIT] = normal_like ? COUNT_OVERFLOW_IN : MODE_OVF_EVENT_IN;
  assign {set_w[7:6], set_w[4:3]} = 4'h0;

  // vector ack bits: [3] match b, [2] capture, [1] match a, [0] overflow
  // flag clear
  assign clr_w = (wr_flag ? WDATA_IN : 8'h00) |
                 {2'b00, VECTOR_ACK_IN[2], 2'b00, VECTOR_ACK_IN[3], VECTOR_ACK_IN[1],
                  VECTOR_ACK_IN[0]}
                 | (force_seen ? 8'h00 : 8'h00);

  assign flag_d = ((flag_q & ~clr_w) | set_w) & t16i_pkg::IRQ_USED_MASK;

  always_ff @(posedge CLK_SYS_IN)
  begin
    if (!RSTN_IN)
      flag_q <= t16i_pkg::FLAG_RESET;
    else
      flag_q <= flag_d;
  end

  always_ff @(posedge CLK_SYS_IN)
  begin
    if (!RSTN_IN)
      mask_q <= t16i_pkg::MASK_RESET;
    else if (wr_mask)
      mask_q <= WDATA_IN & t16i_pkg::IRQ_USED_MASK;
  end

  // ------------------------------------------------------------
  // interrupt requests and read mux
  // ------------------------------------------------------------
  wire [7:0] req_w = flag_q & mask_q & {8{GLOBAL_IE_IN}};
  assign IRQ_CAPTURE_OUT  = req_w[t16i_pkg::CAP_BIT];
  assign IRQ_MATCH_A_OUT  = req_w[t16i_pkg::MA_BIT];
  assign IRQ_MATCH_B_OUT  = req_w[t16i_pkg::MB_BIT];
  assign IRQ_OVERFLOW_OUT = req_w[t16i_pkg::OVF_BIT];
  assign FLAGS_OUT        = flag_q;

  // high byte read returns the copy frozen by the low read
  // coherent read
  always_comb
  begin
    RDATA_OUT = 8'h00;
    case (ADDR_IN)
      t16i_pkg::GTC_ADDR:  RDATA_OUT = gtc_q;
      t16i_pkg::MASK_ADDR: RDATA_OUT = mask_q;
      t16i_pkg::FLAG_ADDR: RDATA_OUT = flag_q;
      t16i_pkg::CAPL_ADDR: RDATA_OUT = cap_q[7:0];
      t16i_pkg::CAPH_ADDR: RDATA_OUT = temp_q;
      default:             RDATA_OUT = 8'h00;
    endcase
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  cap_copy_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    cap_evt |=> cap_q == $past(COUNT_VALUE_IN)) else $error("capture not copied");
  set_wins_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    set_w[t16i_pkg::OVF_BIT] |=> flag_q[t16i_pkg::OVF_BIT]) else $error("set lost");
  w1c_clear_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    (wr_flag && WDATA_IN[0] && !set_w[0]) |=> !flag_q[0]) else $error("w1c failed");
  unused_zero_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    (flag_q & ~t16i_pkg::IRQ_USED_MASK) == 8'h00 && (mask_q & 8'hD8) == 8'h00)
    else $error("unused bit set");
  irq_gate_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    IRQ_MATCH_A_OUT == (flag_q[1] & mask_q[1] & GLOBAL_IE_IN)) else $error("irq gating");
  psr_clear_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    (!sync_hold_mode && !wr_gtc) |=> !sync_prescaler_reset) else $error("reset bit stuck");
  hold_keep_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    (sync_hold_mode && sync_prescaler_reset && !wr_gtc) |=> sync_prescaler_reset && !TICK16_OUT)
    else $error("hold lost");
  pre_restart_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    sync_prescaler_reset |=> pre_q == '0) else $error("prescaler not restarted");
  div8_rate_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    (CLK_SEL16_IN == t16i_pkg::CS_DIV8 && TICK16_OUT && !sync_prescaler_reset) |=>
    !TICK16_OUT [*7]) else $error("div8 rate wrong");
  temp_hold_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    rd_capl |=> temp_q == $past(cap_q[15:8])) else $error("temp not latched");

endmodule : t16i_core

// ### t16i_cpu_model.sv
// cpu-side partner: drives the register port and the vector acknowledges
// assumes writes are taken on the rising edge and reads answer at once
`timescale 1ns/1ps

module t16i_cpu_model
(
  input  wire logic       clk_in,
  input  wire logic [7:0] rdata_in,
  output logic      [7:0] addr_out,
  output logic      [7:0] wdata_out,
  output logic            wr_out,
  output logic            rd_out,
  output logic      [3:0] vector_ack_out
);
  // idle bus at time zero
  initial
  begin
    addr_out       = 8'h00;
    wdata_out      = 8'h00;
    wr_out         = 1'b0;
    rd_out         = 1'b0;
    vector_ack_out = 4'h0;
  end

  // one write; called at a falling edge, strobe spans one rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr_out  = a;
    wdata_out = d;
    wr_out    = 1'b1;
    @(negedge clk_in);
    wr_out    = 1'b0;
    addr_out  = ~a;  // released bus must not show a stale address
    wdata_out = ~d;
    // idle edge so a following call never re-raises a strobe at once
    @(negedge clk_in);
  endtask : wr

  // one read; data is combinational, taken once it has settled
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    addr_out = a;
    rd_out   = 1'b1;
    #1;
    d        = rdata_in;
    @(negedge clk_in);
    rd_out   = 1'b0;
    addr_out = ~a;
    @(negedge clk_in);
  endtask : rd

  // vector execution acknowledge, one cycle
  task automatic ack(input logic [3:0] v);
    vector_ack_out = v;
    @(negedge clk_in);
    vector_ack_out = 4'h0;
  endtask : ack
endmodule : t16i_cpu_model

// ### tb_timer16_irq_and_shared_prescaler.sv
// self-checking bench for the timer16 flags, capture and prescaler block
// assumes t16i_cpu_model as the cpu and a 50 ns system clock
`timescale 1ns/1ps

module tb_timer16_irq_and_shared_prescaler;
  // ------------------------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------------------------
  logic        clk = 1'b0, rstn = 1'b0, gie = 1'b0, top = 1'b0, ovf = 1'b0;
  logic        movf = 1'b0, cap = 1'b0, fa = 1'b0, fb = 1'b0, pin = 1'b0;
  logic [15:0] cnt = 16'h0000, cmpa = 16'h0005, cmpb = 16'h0009, capreg;
  logic [3:0]  wgm = 4'h0;
  logic [2:0]  s16 = 3'h0, s8 = 3'h0;
  logic [3:0]  ack;
  logic [7:0]  addr, wdata, rdata, flags;
  logic        wr, rd, t16, t8, apr, iq_c, iq_a, iq_b, iq_o;
  int          n_mismatch = 0, comparisons = 0, c16, c8, k;
  int          shf [5] = '{0, 3, 6, 8, 10};

  // 20 MHz system clock
  always #25 clk = ~clk;

  t16i_cpu_model i_cpu (.clk_in(clk), .rdata_in(rdata), .addr_out(addr), .wdata_out(wdata),
    .wr_out(wr), .rd_out(rd), .vector_ack_out(ack));

  t16i_core i_dut (.CLK_SYS_IN(clk), .RSTN_IN(rstn), .ADDR_IN(addr), .WDATA_IN(wdata),
    .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .GLOBAL_IE_IN(gie), .VECTOR_ACK_IN(ack),
    .COUNT_VALUE_IN(cnt), .COMPARE_REG_A_IN(cmpa), .COMPARE_REG_B_IN(cmpb),
    .WAVEFORM_MODE_SEL_IN(wgm), .COUNT_AT_TOP_IN(top), .COUNT_OVERFLOW_IN(ovf),
    .MODE_OVF_EVENT_IN(movf), .CAPTURE_EVENT_IN(cap), .FORCE_MATCH_A_IN(fa),
    .FORCE_MATCH_B_IN(fb), .EXTERNAL_COUNT_PIN_IN(pin), .CLK_SEL16_IN(s16),
    .CLK_SEL8_IN(s8), .TICK16_OUT(t16), .TICK8_OUT(t8), .ASYNC_PRESCALER_RESET_OUT(apr),
    .CAPTURE_REGISTER_OUT(capreg), .FLAGS_OUT(flags), .IRQ_CAPTURE_OUT(iq_c),
    .IRQ_MATCH_A_OUT(iq_a), .IRQ_MATCH_B_OUT(iq_b), .IRQ_OVERFLOW_OUT(iq_o));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask : step

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    i_cpu.rd(a, d);
    chk(nm, {8'h00, e}, {8'h00, d});
  endtask : rchk

  // counting on falling edges keeps clear of the launching edge
  task automatic ticks(input int n);
    c16 = 0;
    c8 = 0;
    repeat (n)
    begin
      @(negedge clk);
      c16 += (t16 === 1'b1);
      c8 += (t8 === 1'b1);
    end
  endtask : ticks

  task automatic conclude;
    if (n_mismatch == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude

  // hang guard, well beyond the roughly 10.5k cycles of the sequence
  initial
  begin
    #2_000_000;
    n_mismatch++;
    conclude();
  end

  // ------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------
  initial
  begin
    step(2);
    rstn = 1'b1;
    rchk("gtc_reset", t16i_pkg::GTC_ADDR, 8'h00);
    rchk("mask_reset", t16i_pkg::MASK_ADDR, 8'h00);
    rchk("flag_reset", t16i_pkg::FLAG_ADDR, 8'h00);
    rchk("unmapped", 8'h50, 8'h00);
    i_cpu.wr(t16i_pkg::MASK_ADDR, 8'hFF);
    rchk("mask_bits", t16i_pkg::MASK_ADDR, 8'h27);
    // capture, then a second capture between the two byte reads
    cnt = 16'h1234;
    cap = 1'b1;
    step(1);
    cap = 1'b0;
    chk("cap_value", 16'h1234, capreg);
    chk("cap_flag", 16'h0020, {8'h00, flags});
    rchk("flag_read", t16i_pkg::FLAG_ADDR, 8'h20);
    rchk("cap_low", t16i_pkg::CAPL_ADDR, 8'h34);
    cnt = 16'hABCD;
    cap = 1'b1;
    step(1);
    cap = 1'b0;
    rchk("cap_high", t16i_pkg::CAPH_ADDR, 8'h12);
    gie = 1'b1;
    step(1);
    chk("irq_cap_on", 16'h0001, {15'h0, iq_c});
    gie = 1'b0;
    step(1);
    chk("irq_cap_gie", 16'h0000, {15'h0, iq_c});
    i_cpu.ack(4'h4);
    chk("cap_vec_clr", 16'h0000, {8'h00, flags});
    // capture register as top: event ignored, flag set at top
    wgm = t16i_pkg::WGM_CLR_CAP;
    cnt = 16'h5555;
    cap = 1'b1;
    top = 1'b1;
    step(1);
    cap = 1'b0;
    top = 1'b0;
    chk("cap_at_top", 16'hABCD, capreg);
    chk("top_flag", 16'h0020, {8'h00, flags});
    i_cpu.wr(t16i_pkg::FLAG_ADDR, 8'h20);
    chk("cap_w1c", 16'h0000, {8'h00, flags});
    // overflow in normal mode, vector clear, set beating clear
    wgm = t16i_pkg::WGM_NORMAL;
    gie = 1'b1;
    ovf = 1'b1;
    step(1);
    ovf = 1'b0;
    chk("ovf_flag", 16'h0001, {8'h00, flags});
    chk("irq_ovf", 16'h0001, {15'h0, iq_o});
    i_cpu.ack(4'h1);
    chk("ovf_vec_clr", 16'h0000, {8'h00, flags});
    fork
      i_cpu.wr(t16i_pkg::FLAG_ADDR, 8'h01);
      begin
        ovf = 1'b1;
        step(1);
        ovf = 1'b0;
      end
    join
    chk("set_wins", 16'h0001, {8'h00, flags});
    i_cpu.wr(t16i_pkg::FLAG_ADDR, 8'h01);
    chk("ovf_w1c", 16'h0000, {8'h00, flags});
    // other mode: only the mode event sets overflow
    wgm = t16i_pkg::WGM_PFC_CAP;
    ovf = 1'b1;
    step(1);
    ovf = 1'b0;
    chk("ovf_mode_off", 16'h0000, {8'h00, flags});
    movf = 1'b1;
    step(1);
    movf = 1'b0;
    chk("ovf_mode_on", 16'h0001, {8'h00, flags});
    i_cpu.wr(t16i_pkg::FLAG_ADDR, 8'h01);
    wgm = t16i_pkg::WGM_NORMAL;
    // compare matches with a tick every clock, then forced strobes
    s16 = 3'h1;
    cnt = 16'h0005;
    step(1);
    cnt = 16'h0006;
    step(2);
    chk("match_a", 16'h0002, {8'h00, flags});
    chk("irq_a", 16'h0001, {15'h0, iq_a});
    i_cpu.ack(4'h2);
    chk("a_vec_clr", 16'h0000, {8'h00, flags});
    cnt = 16'h0009;
    step(1);
    cnt = 16'h0006;
    step(2);
    chk("match_b", 16'h0004, {8'h00, flags});
    chk("irq_b", 16'h0001, {15'h0, iq_b});
    i_cpu.wr(t16i_pkg::FLAG_ADDR, 8'h04);
    chk("b_w1c", 16'h0000, {8'h00, flags});
    // match b again, cleared by its vector this time
    cnt = 16'h0009;
    step(1);
    cnt = 16'h0006;
    step(2);
    i_cpu.ack(4'h8);
    chk("b_vec_clr", 16'h0000, {8'h00, flags});
    fa = 1'b1;
    fb = 1'b1;
    step(1);
    fa = 1'b0;
    fb = 1'b0;
    step(2);
    chk("force_none", 16'h0000, {8'h00, flags});
    // every internal select on both timers over whole prescaler periods
    for (int i = 0; i < 5; i++)
    begin
      s16 = 3'(i + 1);
      s8 = 3'(5 - i);
      ticks(2048);
      chk("tick16_rate", 16'(2048 >> shf[i]), 16'(c16));
      chk("tick8_rate", 16'(2048 >> shf[4 - i]), 16'(c8));
    end
    // prescaler reset: self clear, hold mode, joint restart
    i_cpu.wr(t16i_pkg::GTC_ADDR, 8'h01);
    step(1);
    rchk("sync_clr", t16i_pkg::GTC_ADDR, 8'h00);
    i_cpu.wr(t16i_pkg::GTC_ADDR, 8'h83);
    step(1);
    rchk("hold_bits", t16i_pkg::GTC_ADDR, 8'h83);
    chk("async_bit", 16'h0001, {15'h0, apr});
    s16 = 3'h2;
    s8 = 3'h2;
    ticks(100);
    chk("held_ticks", 16'h0000, 16'(c16 + c8));
    i_cpu.wr(t16i_pkg::GTC_ADDR, 8'h03);
    k = 0;
    while (t16 !== 1'b1 && k < 20)
    begin
      step(1);
      k++;
    end
    chk("first_tick", 16'h0001, {15'h0, (k >= 1 && k <= 9)});
    chk("joint_tick", 16'h0001, {15'h0, t8});
    step(1);
    rchk("mode_release", t16i_pkg::GTC_ADDR, 8'h00);
    chk("async_off", 16'h0000, {15'h0, apr});
    // external pin: stable before enabling, half period of 3 clocks
    s16 = 3'h0;
    s8 = 3'h0;
    step(2);
    s16 = t16i_pkg::CS_EXTR;
    s8 = t16i_pkg::CS_EXTF;
    step(2);
    pin = 1'b1;
    k = 0;
    while (t16 !== 1'b1 && k < 8)
    begin
      step(1);
      k++;
    end
    chk("ext_latency", 16'h0001, {15'h0, (k >= 2 && k <= 4)});
    fork
      repeat (8)
      begin
        step(3);
        pin = ~pin;
      end
      ticks(30);
    join
    chk("ext_rise", 16'h0004, 16'(c16));
    chk("ext_fall", 16'h0004, 16'(c8));
    // mid-run reset with the external clock deselected first
    s16 = 3'h0;
    s8 = 3'h0;
    step(2);
    rstn = 1'b0;
    step(2);
    rstn = 1'b1;
    rchk("mask_rerst", t16i_pkg::MASK_ADDR, 8'h00);
    chk("cap_rerst", 16'h0000, capreg);
    conclude();
  end
endmodule : tb_timer16_irq_and_shared_prescaler
